// [acs_top.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_top import acs_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  input wire logic comp_in,
  output logic dout_out,
  output logic dout_oe_n_out,
  output logic [7:0] mux_sel_out,
  output logic track_out,
  output logic hold_out,
  output logic powered_out,
  output logic [RES_W-1:0] dac_out,
  output logic res_valid_out,
  output logic [FIFO_W-1:0] res_data_out,
  input wire logic res_ready_in,
  output logic res_drop_out
);
  // ==========================================================
  // reset release and pin sampling
  logic [1:0] rst_pipe_q;
  logic rst_n_q;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic sclk_p_q;
  logic cs_n_p_q;

  // release reset through two flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_pipe_q[1];

  acs_sync #(.W(3)) u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_q),
    .ce_in(ce_in),
    .d_in({sclk_in, cs_n_in, din_in}),
    .rst_val_in(3'b010),
    .q_out({sclk_s, cs_n_s, din_s})
  );

  // previous samples for edge finding
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_p_q <= 1'b0;
      cs_n_p_q <= 1'b1;
    end else if (ce_in) begin
      sclk_p_q <= sclk_s;
      cs_n_p_q <= cs_n_s;
    end
  end

  // ==========================================================
  // link events
  logic active;
  logic cs_fall;
  logic fall_ev;
  logic rise_ev;

  // a chip select fall with clock low is the first falling edge
  assign active = !cs_n_s;
  assign cs_fall = ce_in && cs_n_p_q && !cs_n_s;
  assign fall_ev = ce_in && active && ((sclk_p_q && !sclk_s) || (cs_fall && !sclk_s));
  assign rise_ev = ce_in && active && !sclk_p_q && sclk_s;

  // ==========================================================
  // edge counters
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  logic [4:0] rise_cnt_q;
  logic [4:0] rise_cnt_d;

  // falling edges wrap from sixteen into the next conversion
  always_comb begin
    fall_cnt_d = fall_cnt_q;
    if (!active) begin
      fall_cnt_d = CNT_IDLE;
    end else if (fall_ev) begin
      if (fall_cnt_q == CONV_EDGES || fall_cnt_q == CNT_IDLE) begin
        fall_cnt_d = CNT_FIRST;
      end else begin
        fall_cnt_d = fall_cnt_q + 5'h01;
      end
    end
  end

  // rising edges restart at each frame start
  always_comb begin
    rise_cnt_d = rise_cnt_q;
    if (!active || cs_fall) begin
      rise_cnt_d = CNT_IDLE;
    end
    if (rise_ev) begin
      rise_cnt_d = (rise_cnt_q == CONV_EDGES || cs_fall) ? CNT_FIRST : rise_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fall_cnt_q <= CNT_IDLE;
      rise_cnt_q <= CNT_IDLE;
    end else if (ce_in) begin
      fall_cnt_q <= fall_cnt_d;
      rise_cnt_q <= rise_cnt_d;
    end
  end

  // ==========================================================
  // control word
  logic [CTRL_W-1:0] shift_q;
  logic [CHAN_W-1:0] chan_addr_q;
  logic [CHAN_W-1:0] chan_q;
  logic [CTRL_W-1:0] word_in;

  assign word_in = {shift_q[CTRL_W-2:0], din_s};

  // shift in msb first, keep only the channel field
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_q <= CTRL_RST;
      chan_addr_q <= CTRL_RST[CHAN_MSB:CHAN_LSB];
    end else if (rise_ev && rise_cnt_d <= CAP_RISES) begin
      shift_q <= word_in;
      if (rise_cnt_d == CAP_RISES) begin
        chan_addr_q <= word_in[CHAN_MSB:CHAN_LSB];
      end
    end
  end

  // channel in use is fixed at the first falling edge
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chan_q <= '0;
    end else if (fall_ev && fall_cnt_d == CNT_FIRST) begin
      chan_q <= chan_addr_q;
    end
  end

  // input multiplexer, code seven grounds the sampler
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mux_sel_out <= 8'h01;
    end else if (ce_in) begin
      mux_sel_out <= 8'h01 << chan_q;
    end
  end

  // ==========================================================
  // phase and power
  acs_phase_t phase_q;
  acs_phase_t phase_d;

  always_comb begin
    phase_d = phase_q;
    if (!active) begin
      phase_d = PH_OFF;
    end else if (fall_ev) begin
      case (fall_cnt_d)
        CNT_FIRST, 5'h02, TRACK_LAST: begin
          phase_d = PH_TRACK;
        end
        CONV_EDGES: begin
          phase_d = PH_DOWN;
        end
        default: begin
          phase_d = PH_HOLD;
        end
      endcase
    end
  end

  // phase with its registered outputs
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= PH_OFF;
      track_out <= 1'b0;
      hold_out <= 1'b0;
      powered_out <= 1'b0;
    end else if (ce_in) begin
      phase_q <= phase_d;
      track_out <= (phase_d == PH_TRACK);
      hold_out <= (phase_d == PH_HOLD);
      powered_out <= active && (phase_d != PH_DOWN);
    end
  end

  // ==========================================================
  // approximation and serial output
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] sar_d;
  logic [3:0] bidx;

  assign bidx = acs_bit_idx(fall_cnt_d);

  // one bit decided per falling edge, next bit put on trial
  always_comb begin
    sar_d = sar_q;
    if (fall_ev && fall_cnt_d == HOLD_FIRST) begin
      sar_d = SAR_FIRST;
    end else if (fall_ev && fall_cnt_d > HOLD_FIRST) begin
      sar_d[bidx] = comp_in;
      if (bidx != 4'h0) begin
        sar_d[bidx - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sar_q <= '0;
    end else if (ce_in) begin
      sar_q <= sar_d;
    end
  end
  assign dac_out = sar_q;

  // leading zeros then result bits on falling edges
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dout_out <= 1'b0;
      dout_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      dout_oe_n_out <= !active;
      if (!active) begin
        dout_out <= 1'b0;
      end else if (fall_ev) begin
        dout_out <= (fall_cnt_d <= ZERO_LAST) ? 1'b0 : comp_in;
      end
    end
  end

  // ==========================================================
  // finished results toward the buffer
  logic push_q;
  logic [FIFO_W-1:0] push_data_q;
  logic fifo_ready;

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      push_q <= 1'b0;
      push_data_q <= '0;
      res_drop_out <= 1'b0;
    end else if (ce_in) begin
      push_q <= fall_ev && (fall_cnt_d == CONV_EDGES);
      if (fall_ev && fall_cnt_d == CONV_EDGES) begin
        push_data_q <= {chan_q, sar_d};
      end
      res_drop_out <= push_q && !fifo_ready; // full buffer loses the word
    end
  end

  acs_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_q),
    .ce_in(ce_in),
    .in_valid_in(push_q),
    .in_data_in(push_data_q),
    .in_ready_out(fifo_ready),
    .out_valid_out(res_valid_out),
    .out_data_out(res_data_out),
    .out_ready_in(res_ready_in)
  );

  // ==========================================================
  // checks
  property p_drop_bits;
    @(posedge clock_in) disable iff (!rst_n_q)
    rise_ev && rise_cnt_d == CAP_RISES |=> chan_addr_q == $past(word_in[CHAN_MSB:CHAN_LSB]);
  endproperty
  a_drop_bits: assert property (p_drop_bits) else $error("channel field not taken");

  property p_next_chan;
    @(posedge clock_in) disable iff (!rst_n_q)
    fall_ev && fall_cnt_d == CNT_FIRST |=> chan_q == $past(chan_addr_q);
  endproperty
  a_next_chan: assert property (p_next_chan) else $error("channel not latched");

  property p_mux;
    @(posedge clock_in) disable iff (!rst_n_q)
    ce_in |=> $onehot(mux_sel_out) && mux_sel_out[$past(chan_q)];
  endproperty
  a_mux: assert property (p_mux) else $error("mux select wrong");

  property p_track;
    @(posedge clock_in) disable iff (!rst_n_q)
    fall_ev && fall_cnt_d <= TRACK_LAST |=> track_out && !hold_out;
  endproperty
  a_track: assert property (p_track) else $error("track phase wrong");

  property p_hold;
    @(posedge clock_in) disable iff (!rst_n_q)
    fall_ev && fall_cnt_d >= HOLD_FIRST && fall_cnt_d < CONV_EDGES |=> hold_out && !track_out;
  endproperty
  a_hold: assert property (p_hold) else $error("hold phase wrong");

  property p_reset_word;
    @(posedge clock_in)
    $rose(rst_n_q) |-> chan_addr_q == '0 && chan_q == '0;
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("control word not cleared");

  property p_result;
    @(posedge clock_in) disable iff (!rst_n_q)
    push_q |-> push_data_q[RES_W-1:0] == sar_q;
  endproperty
  a_result: assert property (p_result) else $error("result differs from register");

  property p_power;
    @(posedge clock_in) disable iff (!rst_n_q)
    ce_in && cs_n_s |=> !powered_out ##1 (!ce_in || !powered_out || !cs_n_s);
  endproperty
  a_power: assert property (p_power) else $error("powered with chip select high");

  property p_sleep;
    @(posedge clock_in) disable iff (!rst_n_q)
    fall_ev && fall_cnt_d == CONV_EDGES |=> !powered_out && phase_q == PH_DOWN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no power down after last edge");

  property p_wrap;
    @(posedge clock_in) disable iff (!rst_n_q)
    fall_ev && active && fall_cnt_q == CONV_EDGES |=> fall_cnt_q == CNT_FIRST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("conversion did not restart");

  property p_late_din;
    @(posedge clock_in) disable iff (!rst_n_q)
    rise_ev && rise_cnt_d > CAP_RISES |=> $stable(shift_q) && $stable(chan_addr_q);
  endproperty
  a_late_din: assert property (p_late_din) else $error("late rising edge captured");

  property p_zeros;
    @(posedge clock_in) disable iff (!rst_n_q)
    fall_ev && fall_cnt_d <= ZERO_LAST |=> !dout_out && !dout_oe_n_out;
  endproperty
  a_zeros: assert property (p_zeros) else $error("leading bit not zero");
endmodule // acs_top
`default_nettype wire

// [acs_pkg.sv]
// ==========================================================
// shared constants for the channel select sequencer
package acs_pkg;
  // control word layout
  localparam int CTRL_W = 8;
  localparam int CHAN_MSB = 5;
  localparam int CHAN_LSB = 3;
  localparam int CHAN_W = CHAN_MSB - CHAN_LSB + 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] CHAN_GND = 3'h7;
  // conversion timing in serial clock edges
  localparam logic [4:0] CNT_IDLE = 5'h00;
  localparam logic [4:0] CNT_FIRST = 5'h01;
  localparam logic [4:0] TRACK_LAST = 5'h03;
  localparam logic [4:0] HOLD_FIRST = 5'h04;
  localparam logic [4:0] ZERO_LAST = 5'h04;
  localparam logic [4:0] CAP_RISES = 5'h08;
  localparam logic [4:0] CONV_EDGES = 5'h10;
  // result layout
  localparam int RES_W = 12;
  localparam logic [11:0] SAR_FIRST = 12'h800;
  localparam int FIFO_W = CHAN_W + RES_W;
  localparam int FIFO_DEPTH = 16;
  // conversion phase
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_TRACK = 2'b01,
    PH_HOLD = 2'b10,
    PH_DOWN = 2'b11
  } acs_phase_t;
  // bit of the result decided on a given falling edge
  function automatic logic [3:0] acs_bit_idx(input logic [4:0] edge_n);
    logic [4:0] d;
    d = CONV_EDGES - edge_n;
    return d[3:0];
  endfunction
endpackage

// [acs_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two flop synchroniser for pin inputs
module acs_sync import acs_pkg::*; #(
  parameter int W = 3
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  input wire logic [W-1:0] rst_val_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic seeded_q;
  // first stage read only by second stage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
      seeded_q <= 1'b0;
    end else if (ce_in) begin
      meta_q <= d_in;
      seeded_q <= 1'b1;
      sync_q <= seeded_q ? meta_q : rst_val_in;
    end
  end
  // idle levels until the first sample, so no false chip select fall after reset
  assign q_out = seeded_q ? sync_q : rst_val_in;
endmodule // acs_sync
`default_nettype wire

// [acs_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// result buffer with registered head word
module acs_fifo import acs_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic ovalid_q;
  logic [W-1:0] odata_q;
  logic push;
  logic pop;
  // pop memory into head register when it is free
  assign push = ce_in && in_valid_in && (cnt_q != (AW + 1)'(DEPTH));
  assign pop = ce_in && (cnt_q != '0) && (!ovalid_q || out_ready_in);
  assign in_ready_out = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid_out = ovalid_q;
  assign out_data_out = odata_q;
  // storage
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end
  // pointers and fill count
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  // head register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovalid_q <= 1'b0;
      odata_q <= '0;
    end else if (ce_in) begin
      if (pop) begin
        ovalid_q <= 1'b1;
        odata_q <= mem_q[rd_q];
      end else if (out_ready_in) begin
        ovalid_q <= 1'b0;
      end
    end
  end
endmodule // acs_fifo
`default_nettype wire

// [acs_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial master model: frames conversions, writes control words, reads results
module acs_host (
  input wire logic clock_in,
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  logic [15:0] rx_q[$];
  // link idles deselected with the clock parked low
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  // idle cycles; a released data line keeps toggling
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock_in);
      din_out <= ~din_out;
    end
  endtask
  // back to back conversions, 800 ns serial clock period
  task automatic frame(input logic [7:0] words[$]);
    logic [15:0] rx;
    foreach (words[k]) begin
      for (int i = 0; i < 16; i++) begin
        @(posedge clock_in);
        if (k == 0 && i == 0) begin
          cs_n_out <= 1'b0;
        end else begin
          sclk_out <= 1'b0;
        end
        din_out <= (i < 8) ? words[k][7 - i] : ~din_out;
        repeat (4) @(posedge clock_in);
        sclk_out <= 1'b1;
        // read late in the high phase: the answer trails pin edges
        repeat (3) @(posedge clock_in);
        rx = {rx[14:0], dout_in};
      end
      rx_q.push_back(rx);
    end
    @(posedge clock_in);
    cs_n_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    sclk_out <= 1'b0;
  endtask
endmodule // acs_host
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; $display("[FAIL] %0t %s", $time, msg); end end
module tb import acs_pkg::*;;
  logic clock_in;
  logic rst_n_in;
  logic ce_in;
  logic sclk;
  logic cs_n;
  logic din;
  logic comp_in;
  logic dout_out;
  logic dout_oe_n_out;
  logic [7:0] mux_sel_out;
  logic track_out;
  logic hold_out;
  logic powered_out;
  logic [RES_W-1:0] dac_out;
  logic res_valid_out;
  logic [FIFO_W-1:0] res_data_out;
  logic res_ready_in;
  logic res_drop_out;
  logic stall;
  logic [11:0] ain[8];
  logic [11:0] samp;
  logic [2:0] prev_chan;
  logic [FIFO_W-1:0] exp_q[$];
  logic [31:0] seed = 32'hc9a5;
  int n_mismatch;
  int n_compared;
  int n_drop;
  // ==========================================================
  // instances
  acs_top acs_top_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .comp_in(comp_in), .dout_out(dout_out), .dout_oe_n_out(dout_oe_n_out),
    .mux_sel_out(mux_sel_out), .track_out(track_out), .hold_out(hold_out), .powered_out(powered_out),
    .dac_out(dac_out), .res_valid_out(res_valid_out), .res_data_out(res_data_out),
    .res_ready_in(res_ready_in), .res_drop_out(res_drop_out));
  // a released output line reads inverted, so a late enable shows up as wrong bits
  acs_host acs_host_i (.clock_in(clock_in), .dout_in(dout_oe_n_out ? ~dout_out : dout_out), .sclk_out(sclk),
    .cs_n_out(cs_n), .din_out(din));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int sel_idx(input logic [7:0] m);
    int r;
    r = 0;
    for (int j = 0; j < 8; j++) begin
      if (m[j] === 1'b1) r = j;
    end
    return r;
  endfunction
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    #(20000 * 100);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
  // ==========================================================
  // analog side: track the selected input, compare with the trial word
  always @(posedge clock_in) begin
    if (track_out === 1'b1) samp <= ain[sel_idx(mux_sel_out)];
    comp_in <= (samp >= dac_out);
  end
  // consumer with random stalls, checks every popped word
  always @(posedge clock_in) begin
    if ((res_valid_out & res_ready_in & ce_in) === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected result")
      else `CHK(res_data_out, exp_q.pop_front(), "result word")
    end
    if (res_drop_out === 1'b1 && ce_in === 1'b1) n_drop++;
    res_ready_in <= stall ? 1'b0 : rnd() > 32'h6000_0000;
  end
  // ==========================================================
  // one frame of n conversions; channel codes walk from base
  task automatic run(input int n, input int base, input int keep);
    logic [7:0] w[$];
    logic [FIFO_W-1:0] e[$];
    logic [2:0] c;
    for (int j = 0; j < 7; j++) begin
      ain[j] = 12'(rnd());
    end
    for (int k = 0; k < n; k++) begin
      c = prev_chan;
      w.push_back((8'(rnd()) & 8'hc7) | 8'(((base + k) % 8) << 3));
      prev_chan = w[k][CHAN_MSB:CHAN_LSB];
      e.push_back({c, ((c == CHAN_GND) ? 12'h000 : ain[c])});
      if (k < keep) exp_q.push_back(e[k]);
    end
    acs_host_i.frame(w);
    foreach (e[k]) begin
      `CHK(acs_host_i.rx_q.pop_front(), {4'h0, e[k][RES_W-1:0]}, "serial result")
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    ce_in = 1'b1;
    rst_n_in = 1'b0;
    res_ready_in = 1'b0;
    comp_in = 1'b0;
    samp = 12'h000;
    stall = 1'b0;
    prev_chan = 3'h0;
    ain[7] = 12'h000;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    acs_host_i.idle(8);
    `CHK(mux_sel_out, 8'h01, "default input")
    run(9, 0, 9);
    acs_host_i.idle(40);
    `CHK(exp_q.size(), 0, "results drained")
    `CHK(powered_out, 1'b0, "power while deselected")
    `CHK(dout_oe_n_out, 1'b1, "output released")
    `CHK(hold_out, 1'b0, "hold after frame")
    // buffer fills with the consumer stalled: one word lost
    stall <= 1'b1;
    run(18, 3, 17);
    acs_host_i.idle(20);
    `CHK(n_drop, 1, "dropped words")
    // clock enable low freezes the buffer head while the consumer is ready
    ce_in <= 1'b0;
    stall <= 1'b0;
    acs_host_i.idle(20);
    `CHK(res_valid_out, 1'b1, "head held while disabled")
    `CHK(exp_q.size(), 17, "no pop while disabled")
    ce_in <= 1'b1;
    acs_host_i.idle(300);
    `CHK(exp_q.size(), 0, "buffer drained")
    // reset between frames clears the pending channel
    run(1, 5, 1);
    acs_host_i.idle(40);
    rst_n_in <= 1'b0;
    acs_host_i.idle(2);
    rst_n_in <= 1'b1;
    prev_chan = 3'h0;
    acs_host_i.idle(8);
    `CHK(mux_sel_out, 8'h01, "input after reset")
    run(2, 2, 2);
    acs_host_i.idle(40);
    `CHK(exp_q.size(), 0, "final results drained")
    final_report;
  end
endmodule // tb
`default_nettype wire
